// ===== src/csf_status_bank.sv
// Command response status register and channel ready flag register bank.
// Assumes the bus slave delivers one-cycle read and write strobes with a byte address on mclk_in,
// and the command engine reports its outcomes as one-cycle pulses on the same clock.
//
// How it works
// R1: Bits 7, 6 and 5 of the response register show running, suspended and sleeping.
// R2: The command error flag in bit 4 is cleared by hardware reset, software reset and the tally clear command.
// R3: Any bad command reported by the engine sets the command error flag.
// R4: While the error flag is set the low field shows the error code instead of the tally.
// R5: Without an error, each good command adds one to the four-bit tally.
// R6: The tally clear command loads the tally with zero.
// R7: Hardware or software reset loads the tally with all ones.
// R8: A bad command code reads 0x10 and a bad parameter location 0x11 in the low five bits.
// R9: Converter saturation reads 0x12 and a burst needing over 26 output bytes 0x13.
// R10: After reset the state reads running, and sleeping or the engine state once initialisation ends.
// R11: Bits 7 and 6 of the flag register read zero and writes to them are ignored.
// R12: Bits 0 to 5 of the flag register are the ready flags of channels 0 to 5.
// R13: The six low bits of the mask register choose which ready flags drive the interrupt output.
// R14: Reading the flag register clears the ready flags, which are zero after reset.
// R15: The host reads the response after each command and treats a set error flag as failure.
`timescale 1ns/1ps
module csf_status_bank
  import csf_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic soft_reset_in,
  input wire logic tally_clear_in,
  input wire logic cmd_good_in,
  input wire logic cmd_fault_in,
  input wire csf_fault_t fault_kind_in,
  input wire logic init_done_in,
  input wire csf_seq_t seq_state_in,
  input wire logic [CSF_NUM_CHAN-1:0] chan_ready_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic irq_out
);

  typedef struct packed {
    logic init_done;
    csf_seq_t seq;
    logic cmd_err;
    logic [CSF_TALLY_W-1:0] field;
    logic [CSF_NUM_CHAN-1:0] mask;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
  } csf_state_t;

  localparam csf_state_t CSF_STATE_RESET = '{
    init_done: 1'b0,
    seq: CSF_SEQ_RUNNING,
    cmd_err: 1'b0,
    field: CSF_TALLY_FRESH,
    mask: CSF_MASK_RESET,
    rdata: CSF_BYTE_ZERO,
    rvalid: 1'b0,
    irq: 1'b0
  };

  csf_state_t st_r;
  csf_state_t st_nxt;
  logic [CSF_NUM_CHAN-1:0] flags;
  logic flag_read;
  logic [7:0] response_byte;
  logic [4:0] fault_value;

  // ***************************************************************
  // Channel ready flags
  // ***************************************************************
  assign flag_read = reg_rd_in && (reg_addr_in == CSF_OFS_READY_FLAGS);

  csf_ready_flags u_flags (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .soft_reset_in(soft_reset_in),
    .set_in(chan_ready_in),
    .clear_in(flag_read),
    .flags_out(flags)
  );

  // ***************************************************************
  // Response byte and fault encoding
  // ***************************************************************
  always_comb begin
    response_byte = CSF_BYTE_ZERO;
    response_byte[CSF_BIT_RUNNING] = (st_r.seq == CSF_SEQ_RUNNING); // [R1]
    response_byte[CSF_BIT_SUSPENDED] = (st_r.seq == CSF_SEQ_SUSPENDED); // [R1]
    response_byte[CSF_BIT_SLEEPING] = (st_r.seq == CSF_SEQ_SLEEPING); // [R1]
    response_byte[CSF_BIT_CMD_ERR] = st_r.cmd_err;
    response_byte[CSF_TALLY_W-1:0] = st_r.field; // [R4]
  end

  always_comb begin
    case (fault_kind_in)
      CSF_FAULT_BAD_CODE: fault_value = CSF_ERR_BAD_CODE; // [R8]
      CSF_FAULT_BAD_PARAM: fault_value = CSF_ERR_BAD_PARAM; // [R8]
      CSF_FAULT_SATURATE: fault_value = CSF_ERR_SATURATE; // [R9]
      default: fault_value = CSF_ERR_OUT_OVF; // [R9]
    endcase
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;

    // Engine state is shown only once initialisation has finished
    if (st_r.init_done) begin
      st_nxt.seq = seq_state_in; // [R10]
    end else if (init_done_in) begin
      st_nxt.init_done = 1'b1;
      st_nxt.seq = CSF_SEQ_SLEEPING; // [R10]
    end

    // Command outcomes, most urgent first
    if (tally_clear_in) begin
      st_nxt.cmd_err = 1'b0; // [R2]
      st_nxt.field = CSF_TALLY_ZERO; // [R6]
    end else if (cmd_fault_in) begin
      st_nxt.cmd_err = fault_value[CSF_BIT_CMD_ERR]; // [R3]
      st_nxt.field = fault_value[CSF_TALLY_W-1:0]; // [R4] [R8] [R9]
    end else if (cmd_good_in && !st_r.cmd_err) begin
      st_nxt.field = st_r.field + CSF_TALLY_ONE; // [R5]
    end

    // Mask register; only the six low bits are held
    if (reg_wr_in && (reg_addr_in == CSF_OFS_READY_MASK)) begin
      st_nxt.mask = reg_wdata_in[CSF_NUM_CHAN-1:0]; // [R13]
    end

    // Register reads; unmapped addresses answer zero, writes to the flag register are dropped
    if (reg_rd_in) begin
      st_nxt.rvalid = 1'b1;
      if (reg_addr_in == CSF_OFS_RESPONSE) begin
        st_nxt.rdata = response_byte;
      end else if (reg_addr_in == CSF_OFS_READY_FLAGS) begin
        st_nxt.rdata = {CSF_UNUSED_ZERO, flags}; // [R11] [R12]
      end else if (reg_addr_in == CSF_OFS_READY_MASK) begin
        st_nxt.rdata = {CSF_UNUSED_ZERO, st_r.mask};
      end else begin
        st_nxt.rdata = CSF_BYTE_ZERO;
      end
    end

    st_nxt.irq = |(flags & st_r.mask); // [R13]

    // Software reset restores every reset value and restarts initialisation
    if (soft_reset_in) begin
      st_nxt = CSF_STATE_RESET; // [R2] [R7] [R10]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_r <= CSF_STATE_RESET; // [R2] [R7] [R10]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign reg_rvalid_out = st_r.rvalid;
  assign irq_out = st_r.irq;

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_quiet;
    !soft_reset_in && !tally_clear_in && !cmd_fault_in;
  endsequence

  sequence s_good_cmd;
    cmd_good_in && !st_r.cmd_err ##0 s_quiet;
  endsequence

  sequence s_rd_flags;
    reg_rd_in && (reg_addr_in == CSF_OFS_READY_FLAGS) && !soft_reset_in;
  endsequence

  AST_STATE_BITS: assert property (@(posedge mclk_in) disable iff (srst_in) // [R1]
    (reg_rd_in && reg_addr_in == CSF_OFS_RESPONSE && !soft_reset_in)
      |=> reg_rvalid_out && (reg_rdata_out[7:5] == {$past(st_r.seq == CSF_SEQ_RUNNING),
        $past(st_r.seq == CSF_SEQ_SUSPENDED), $past(st_r.seq == CSF_SEQ_SLEEPING)}))
    else $error("response state bits wrong");

  AST_ERR_CLEAR: assert property (@(posedge mclk_in) disable iff (srst_in) // [R2]
    (tally_clear_in || soft_reset_in) |=> !st_r.cmd_err)
    else $error("error flag not cleared");

  AST_ERR_SET: assert property (@(posedge mclk_in) disable iff (srst_in) // [R3]
    (cmd_fault_in && !tally_clear_in && !soft_reset_in) |=> st_r.cmd_err)
    else $error("error flag not set by fault");

  AST_ERR_HOLDS_CODE: assert property (@(posedge mclk_in) disable iff (srst_in) // [R4]
    (st_r.cmd_err && cmd_good_in) ##0 s_quiet |=> st_r.field == $past(st_r.field))
    else $error("tally moved while error shown");

  AST_TALLY_INC: assert property (@(posedge mclk_in) disable iff (srst_in) // [R5]
    s_good_cmd |=> st_r.field == $past(st_r.field) + CSF_TALLY_ONE)
    else $error("tally did not advance");

  AST_TALLY_ZERO: assert property (@(posedge mclk_in) disable iff (srst_in) // [R6]
    (tally_clear_in && !soft_reset_in) |=> st_r.field == CSF_TALLY_ZERO)
    else $error("tally not zeroed");

  AST_TALLY_FRESH: assert property (@(posedge mclk_in) disable iff (srst_in) // [R7]
    soft_reset_in |=> (st_r.field == CSF_TALLY_FRESH) && (st_r.seq == CSF_SEQ_RUNNING))
    else $error("reset values not loaded");

  AST_FAULT_CODE: assert property (@(posedge mclk_in) disable iff (srst_in) // [R8]
    (cmd_fault_in && fault_kind_in == CSF_FAULT_BAD_PARAM && !tally_clear_in && !soft_reset_in)
      |=> {st_r.cmd_err, st_r.field} == CSF_ERR_BAD_PARAM)
    else $error("bad parameter code wrong");

  AST_OVF_CODE: assert property (@(posedge mclk_in) disable iff (srst_in) // [R9]
    (cmd_fault_in && fault_kind_in == CSF_FAULT_OUT_OVF && !tally_clear_in && !soft_reset_in)
      |=> {st_r.cmd_err, st_r.field} == CSF_ERR_OUT_OVF)
    else $error("overflow code wrong");

  AST_INIT_SLEEP: assert property (@(posedge mclk_in) disable iff (srst_in) // [R10]
    (!st_r.init_done && init_done_in && !soft_reset_in) |=> st_r.seq == CSF_SEQ_SLEEPING)
    else $error("not sleeping after init");

  AST_UNUSED_ZERO: assert property (@(posedge mclk_in) disable iff (srst_in) // [R11]
    reg_rvalid_out && $past(reg_addr_in == CSF_OFS_READY_FLAGS) |-> reg_rdata_out[7:6] == CSF_UNUSED_ZERO)
    else $error("unused flag bits not zero");

  AST_READ_CLEARS: assert property (@(posedge mclk_in) disable iff (srst_in) // [R12] [R14]
    s_rd_flags ##0 (chan_ready_in == CSF_FLAGS_RESET) |=> reg_rdata_out[5:0] == $past(flags) ##0 flags == CSF_FLAGS_RESET)
    else $error("flag read did not return and clear");

  AST_IRQ_MASK: assert property (@(posedge mclk_in) disable iff (srst_in) // [R13]
    !soft_reset_in |=> irq_out == |($past(flags) & $past(st_r.mask)))
    else $error("interrupt output not masked flags");

endmodule : csf_status_bank

// ===== src/csf_pkg.sv
// Constants and types of the command status and channel ready flag bank.
// Assumes the register port is driven by the device's bus slave logic on mclk_in.
package csf_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] CSF_OFS_READY_MASK = 8'h0f;
  localparam logic [7:0] CSF_OFS_RESPONSE = 8'h11;
  localparam logic [7:0] CSF_OFS_READY_FLAGS = 8'h12;

  // ***************************************************************
  // Field layout
  // ***************************************************************
  localparam int CSF_NUM_CHAN = 6;
  localparam int CSF_BIT_RUNNING = 7;
  localparam int CSF_BIT_SUSPENDED = 6;
  localparam int CSF_BIT_SLEEPING = 5;
  localparam int CSF_BIT_CMD_ERR = 4;
  localparam int CSF_TALLY_W = 4;

  // ***************************************************************
  // Reset and load values
  // ***************************************************************
  localparam logic [3:0] CSF_TALLY_FRESH = 4'hf;
  localparam logic [3:0] CSF_TALLY_ZERO = 4'h0;
  localparam logic [3:0] CSF_TALLY_ONE = 4'h1;
  localparam logic [5:0] CSF_FLAGS_RESET = 6'h00;
  localparam logic [5:0] CSF_MASK_RESET = 6'h00;
  localparam logic [7:0] CSF_BYTE_ZERO = 8'h00;
  localparam logic [1:0] CSF_UNUSED_ZERO = 2'h0;

  // Error values, shown in the low five bits while the error flag is set
  localparam logic [4:0] CSF_ERR_BAD_CODE = 5'h10;
  localparam logic [4:0] CSF_ERR_BAD_PARAM = 5'h11;
  localparam logic [4:0] CSF_ERR_SATURATE = 5'h12;
  localparam logic [4:0] CSF_ERR_OUT_OVF = 5'h13;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    CSF_SEQ_RUNNING,
    CSF_SEQ_SUSPENDED,
    CSF_SEQ_SLEEPING
  } csf_seq_t;

  typedef enum logic [1:0] {
    CSF_FAULT_BAD_CODE,
    CSF_FAULT_BAD_PARAM,
    CSF_FAULT_SATURATE,
    CSF_FAULT_OUT_OVF
  } csf_fault_t;

endpackage : csf_pkg

// ===== src/csf_ready_flags.sv
// Sticky per-channel result-ready flags, cleared as a whole by a read strobe.
// Assumes set and clear strobes come from logic on mclk_in.
`timescale 1ns/1ps
module csf_ready_flags
  import csf_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic soft_reset_in,
  input wire logic [CSF_NUM_CHAN-1:0] set_in,
  input wire logic clear_in,
  output logic [CSF_NUM_CHAN-1:0] flags_out
);

  typedef struct packed {
    logic [CSF_NUM_CHAN-1:0] flags;
  } csf_flag_state_t;

  csf_flag_state_t st_r;
  csf_flag_state_t st_nxt;

  // ***************************************************************
  // Per channel flag: set beats a clear in the same cycle
  // ***************************************************************
  logic [CSF_NUM_CHAN-1:0] flag_nxt;

  genvar g;
  generate
    for (g = 0; g < CSF_NUM_CHAN; g++) begin : g_chan
      assign flag_nxt[g] = set_in[g] | (st_r.flags[g] & ~clear_in); // [R12] [R14]
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    if (soft_reset_in) begin
      st_nxt.flags = CSF_FLAGS_RESET; // [R14]
    end else begin
      st_nxt.flags = flag_nxt;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_r <= '{flags: CSF_FLAGS_RESET}; // [R14]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags_out = st_r.flags;

  AST_FLAG_SET_WINS: assert property (@(posedge mclk_in) disable iff (srst_in) // [R14]
    (set_in[0] && !soft_reset_in) |=> flags_out[0])
    else $error("channel ready set lost");

endmodule : csf_ready_flags

// ===== bench/csf_host_model.sv
// Host model: byte register reads and writes on the bank's register port.
// Assumes the bank takes a strobe at a rising edge and answers a read one edge later.
`timescale 1ns/1ps
module csf_host_model (
  input wire logic mclk_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_rvalid_in,
  output logic [7:0] reg_addr_out,
  output logic reg_rd_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
  end

  // Released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge mclk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
    // Idle edge, so the next call never reassigns a line in this time step
    @(posedge mclk_in);
    #1;
  endtask : wr

  // Called just after an edge; returns just after the answer edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge mclk_in);
    #1;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    @(posedge mclk_in);
    ok = reg_rvalid_in;
    d = reg_rdata_in;
    #1;
  endtask : rd
endmodule : csf_host_model

// ===== bench/csf_status_bank_test.sv
// Testbench of the command status and channel ready flag bank.
// Assumes the host model drives the register port; outcome pulses come from here.
`timescale 1ns/1ps
module csf_status_bank_test;
  import csf_pkg::*;
  logic mclk_in, srst_in, soft_reset_in, tally_clear_in, cmd_good_in, cmd_fault_in, init_done_in;
  csf_fault_t fault_kind_in;
  csf_seq_t seq_state_in;
  logic [5:0] chan_ready_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic reg_rd_in, reg_wr_in, reg_rvalid_out, irq_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  csf_status_bank dut (.mclk_in(mclk_in), .srst_in(srst_in), .soft_reset_in(soft_reset_in),
    .tally_clear_in(tally_clear_in), .cmd_good_in(cmd_good_in), .cmd_fault_in(cmd_fault_in),
    .fault_kind_in(fault_kind_in), .init_done_in(init_done_in), .seq_state_in(seq_state_in),
    .chan_ready_in(chan_ready_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .irq_out(irq_out));

  csf_host_model host (.mclk_in(mclk_in), .reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out),
    .reg_addr_out(reg_addr_in), .reg_rd_out(reg_rd_in), .reg_wr_out(reg_wr_in),
    .reg_wdata_out(reg_wdata_in));

  // ***************************************************************
  // Clock and timeout
  // ***************************************************************
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("unexpected at %0t: run did not finish", $time);
      summarize();
    end
  end

  // ***************************************************************
  // Checks and stimulus tasks
  // ***************************************************************
  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    chk1(ok, 1'b1, "read answer");
    chk8(d, exp, "read data");
  endtask : rdc

  // Pulses {soft reset, tally clear, fault, good, init done} and channel ready for one cycle
  task automatic ev(input logic [4:0] v, input csf_fault_t f, input logic [5:0] ch);
    {soft_reset_in, tally_clear_in, cmd_fault_in, cmd_good_in, init_done_in} = v;
    fault_kind_in = f;
    chan_ready_in = ch;
    @(posedge mclk_in);
    #1;
    {soft_reset_in, tally_clear_in, cmd_fault_in, cmd_good_in, init_done_in} = 5'h00;
    chan_ready_in = 6'h00;
    // Idle edge between pulses, so back to back calls never reassign a line at once
    @(posedge mclk_in);
    #1;
  endtask : ev

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    srst_in = 1'b1;
    {soft_reset_in, tally_clear_in, cmd_fault_in, cmd_good_in, init_done_in} = 5'h00;
    fault_kind_in = CSF_FAULT_BAD_CODE;
    seq_state_in = CSF_SEQ_SLEEPING;
    chan_ready_in = 6'h00;
    repeat (20) @(posedge mclk_in);
    #1;
    srst_in = 1'b0;
    rdc(CSF_OFS_RESPONSE, 8'h8f);
    rdc(CSF_OFS_READY_FLAGS, 8'h00);
    rdc(CSF_OFS_READY_MASK, 8'h00);
    ev(5'h01, CSF_FAULT_BAD_CODE, 6'h00);
    rdc(CSF_OFS_RESPONSE, 8'h2f);
    // Engine state is registered, so let one edge pass before reading it back
    seq_state_in = CSF_SEQ_RUNNING;
    @(posedge mclk_in);
    #1;
    rdc(CSF_OFS_RESPONSE, 8'h8f);
    seq_state_in = CSF_SEQ_SUSPENDED;
    @(posedge mclk_in);
    #1;
    rdc(CSF_OFS_RESPONSE, 8'h4f);
    seq_state_in = CSF_SEQ_SLEEPING;
    ev(5'h02, CSF_FAULT_BAD_CODE, 6'h00);
    rdc(CSF_OFS_RESPONSE, 8'h20);
    ev(5'h02, CSF_FAULT_BAD_CODE, 6'h00);
    ev(5'h02, CSF_FAULT_BAD_CODE, 6'h00);
    rdc(CSF_OFS_RESPONSE, 8'h22);
    ev(5'h08, CSF_FAULT_BAD_CODE, 6'h00);
    rdc(CSF_OFS_RESPONSE, 8'h20);
    for (int k = 0; k < 4; k++) begin
      ev(5'h04, csf_fault_t'(k), 6'h00);
      rdc(CSF_OFS_RESPONSE, 8'h30 | 8'(k));
    end
    ev(5'h02, CSF_FAULT_BAD_CODE, 6'h00);
    rdc(CSF_OFS_RESPONSE, 8'h33);
    ev(5'h08, CSF_FAULT_BAD_CODE, 6'h00);
    rdc(CSF_OFS_RESPONSE, 8'h20);
    ev(5'h04, CSF_FAULT_BAD_PARAM, 6'h00);
    ev(5'h10, CSF_FAULT_BAD_CODE, 6'h00);
    rdc(CSF_OFS_RESPONSE, 8'h8f);
    ev(5'h01, CSF_FAULT_BAD_CODE, 6'h00);
    host.wr(CSF_OFS_READY_MASK, 8'hff);
    rdc(CSF_OFS_READY_MASK, 8'h3f);
    for (int n = 0; n < 6; n++) begin
      ev(5'h00, CSF_FAULT_BAD_CODE, 6'h01 << n);
      @(posedge mclk_in);
      #1;
      chk1(irq_out, 1'b1, "irq");
      rdc(CSF_OFS_READY_FLAGS, 8'h01 << n);
      rdc(CSF_OFS_READY_FLAGS, 8'h00);
    end
    host.wr(CSF_OFS_READY_MASK, 8'h05);
    ev(5'h00, CSF_FAULT_BAD_CODE, 6'h02);
    @(posedge mclk_in);
    #1;
    chk1(irq_out, 1'b0, "irq masked");
    ev(5'h00, CSF_FAULT_BAD_CODE, 6'h04);
    @(posedge mclk_in);
    #1;
    chk1(irq_out, 1'b1, "irq enabled");
    host.wr(CSF_OFS_READY_FLAGS, 8'hff);
    rdc(CSF_OFS_READY_FLAGS, 8'h06);
    rdc(CSF_OFS_READY_FLAGS, 8'h00);
    rdc(8'h40, 8'h00);
    summarize();
  end
endmodule : csf_status_bank_test
